// ===== rtl/dpm_consts.vh
// Notes on behaviour
// - address then data on shared lines
// - address stable before select, held after
// - host releases address before device drives
// - select deasserted for recovery between accesses
// - accesses spaced by cycle time
// - data follows address; write ends rising strobe
`ifndef DPM_CONSTS_VH
`define DPM_CONSTS_VH
`define DPM_CLK_PERIOD_NS 8
`define DPM_ADDR_W 9
`define DPM_DATA_W 9
`define DPM_ADDR_SETUP_NS 0
`define DPM_ADDR_HOLD_NS 20
`define DPM_SELECT_ACCESS_NS 120
`define DPM_DRIVE_ENABLE_ACCESS_NS 55
`define DPM_DRIVE_ENABLE_FLOAT_NS 15
`define DPM_DRIVE_HIZ_NS 40
`define DPM_SELECT_HIZ_NS 90
`define DPM_SELECT_RECOVERY_NS 30
`define DPM_CYCLE_NS 150
`define DPM_SELECT_TO_END_WRITE_NS 120
`define DPM_WRITE_TO_END_WRITE_NS 80
`define DPM_DATA_SETUP_NS 40
`define DPM_DATA_HOLD_NS 10
`define DPM_CYC(ns) ((((ns) + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS) < 1 ? 1 : \
   (((ns) + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS))
`endif

// ===== rtl/dpm_host.v
`include "dpm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module dpm_host #(
   parameter ADDR_W = `DPM_ADDR_W,
   parameter DATA_W = `DPM_DATA_W
) (
   input wire clk,
   input wire reset,
   input wire req_valid,
   input wire req_write,
   input wire req_rmw,
   input wire [ADDR_W-1:0] req_addr,
   input wire [DATA_W-1:0] req_wdata,
   output reg req_ready,
   output reg rsp_valid,
   output reg [DATA_W-1:0] rsp_rdata,
   output reg select_n,
   output reg drive_enable_n,
   output reg write_n,
   output reg [DATA_W-1:0] ad_out,
   output reg ad_oe,
   input wire [DATA_W-1:0] ad_in
);
   // whole clock cycles covering a delay, never zero
   function [7:0] cyc8;
      input integer ns;
      integer c;
      begin
         c = (ns + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS;
         if (c < 1) c = 1;
         cyc8 = c[7:0];
      end
   endfunction

   function [7:0] max8;
      input [7:0] a;
      input [7:0] b;
      begin
         max8 = (a > b) ? a : b;
      end
   endfunction

   // saturates at zero so a stalled phase cannot wrap around
   function [7:0] dec8;
      input [7:0] c;
      begin
         dec8 = (c != 8'h00) ? c - 8'h01 : 8'h00;
      end
   endfunction

   // last cycle of a timed phase
   function last1;
      input [7:0] c;
      begin
         last1 = (c == 8'h01);
      end
   endfunction

   localparam [7:0] T_AH = cyc8(`DPM_ADDR_HOLD_NS);
   localparam [7:0] T_RD = cyc8(`DPM_SELECT_ACCESS_NS);
   localparam [7:0] T_OEA = cyc8(`DPM_DRIVE_ENABLE_ACCESS_NS);
   localparam [7:0] T_HIZ = cyc8(`DPM_SELECT_HIZ_NS);
   localparam [7:0] T_REC = cyc8(`DPM_SELECT_RECOVERY_NS);
   localparam [7:0] T_CYC = cyc8(`DPM_CYCLE_NS);
   localparam [7:0] T_WEW = cyc8(`DPM_WRITE_TO_END_WRITE_NS + `DPM_DATA_SETUP_NS);
   localparam [7:0] T_CEW = cyc8(`DPM_SELECT_TO_END_WRITE_NS);
   localparam [7:0] T_DH = cyc8(`DPM_DATA_HOLD_NS);
   localparam [7:0] T_WZ = cyc8(`DPM_DRIVE_HIZ_NS);
   // read samples at the select access delay or one cycle past the drive-enable access delay, whichever is later
   localparam [7:0] T_RD_LEN = max8(T_RD, T_OEA + 8'h01);
   localparam [7:0] T_WR_LEN = max8(T_WEW, T_CEW);

   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_HOLD = 7'h04;
   localparam [6:0] S_READ = 7'h08;
   localparam [6:0] S_WZ = 7'h10;
   localparam [6:0] S_WRITE = 7'h20;
   localparam [6:0] S_END = 7'h40;

   reg [6:0] state_q;
   reg [7:0] cnt_q;
   reg [7:0] sel_cnt_q;
   reg [7:0] gap_q;
   reg wr_q;
   reg rmw_q;
   reg [DATA_W-1:0] wdata_q;

   always @(posedge clk) begin
      if (reset) begin
         state_q <= S_IDLE;
         cnt_q <= 8'h00;
         sel_cnt_q <= 8'h00;
         gap_q <= 8'h00;
         wr_q <= 1'b0;
         rmw_q <= 1'b0;
         wdata_q <= {DATA_W{1'b0}};
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= {DATA_W{1'b0}};
         select_n <= 1'b1;
         drive_enable_n <= 1'b1;
         write_n <= 1'b1;
         ad_out <= {DATA_W{1'b0}};
         ad_oe <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         req_ready <= 1'b0;
         if (gap_q != 8'h00) gap_q <= gap_q - 8'h01;
         if (!select_n) sel_cnt_q <= sel_cnt_q + 8'h01;
         case (state_q)
            S_IDLE: begin
               if (gap_q <= 8'h01 && !req_ready) req_ready <= 1'b1;
               if (req_ready && req_valid) begin
                  req_ready <= 1'b0;
                  wr_q <= req_write;
                  rmw_q <= req_rmw & ~req_write;
                  wdata_q <= req_wdata;
                  ad_out <= req_addr[DATA_W-1:0];
                  ad_oe <= 1'b1;
                  state_q <= S_ADDR;
               end
            end
            S_ADDR: begin
               select_n <= 1'b0;
               sel_cnt_q <= 8'h00;
               gap_q <= T_CYC;
               cnt_q <= T_AH;
               state_q <= S_HOLD;
            end
            S_HOLD: begin
               cnt_q <= dec8(cnt_q);
               if (last1(cnt_q)) begin
                  if (wr_q) begin
                     ad_out <= wdata_q;
                     write_n <= 1'b0;
                     cnt_q <= T_WR_LEN;
                     state_q <= S_WRITE;
                  end else begin
                     // address drivers off in the same edge as the device is enabled
                     ad_oe <= 1'b0;
                     drive_enable_n <= 1'b0;
                     cnt_q <= T_RD_LEN;
                     state_q <= S_READ;
                  end
               end
            end
            S_READ: begin
               cnt_q <= dec8(cnt_q);
               if (last1(cnt_q)) begin
                  rsp_rdata <= ad_in;
                  rsp_valid <= 1'b1;
                  if (rmw_q) begin
                     write_n <= 1'b0;
                     drive_enable_n <= 1'b1;
                     cnt_q <= T_WZ;
                     state_q <= S_WZ;
                  end else begin
                     drive_enable_n <= 1'b1;
                     select_n <= 1'b1;
                     cnt_q <= T_HIZ;
                     state_q <= S_END;
                  end
               end
            end
            S_WZ: begin
               // device drivers still turning off; keep our drivers off
               cnt_q <= dec8(cnt_q);
               if (last1(cnt_q)) begin
                  ad_out <= wdata_q;
                  ad_oe <= 1'b1;
                  cnt_q <= T_WEW;
                  state_q <= S_WRITE;
               end
            end
            S_WRITE: begin
               cnt_q <= dec8(cnt_q);
               if (last1(cnt_q)) begin
                  write_n <= 1'b1;
                  select_n <= 1'b1;
                  cnt_q <= T_DH;
                  state_q <= S_END;
               end
            end
            S_END: begin
               // data held past the write end, then lines released
               cnt_q <= dec8(cnt_q);
               if (last1(cnt_q)) ad_oe <= 1'b0;
               if (cnt_q <= 8'h01 && gap_q <= T_REC) begin
                  ad_oe <= 1'b0;
                  if (gap_q < T_REC) gap_q <= T_REC;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule // dpm_host
`default_nettype wire

// ===== tb/dpm_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_host_props (
   input wire clk,
   input wire reset,
   input wire select_n,
   input wire drive_enable_n,
   input wire write_n,
   input wire ad_oe,
   input wire rsp_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_HOLD: assert property ($fell(select_n) |-> ad_oe[*3]) else $error("addr hold");
   AST_CLASH: assert property (!drive_enable_n && write_n |-> !ad_oe) else $error("clash");
   AST_REC: assert property ($rose(select_n) |-> select_n[*4]) else $error("recovery");
   AST_CYC: assert property ($fell(select_n) |-> !select_n[*8] ##1 !select_n[*8]) else $error("cycle");
   AST_WDAT: assert property ($fell(write_n) && $past(drive_enable_n) |-> ad_oe && !select_n) else $error("wdata");
   AST_RMWZ: assert property ($fell(write_n) && !$past(drive_enable_n) |-> !ad_oe ##5 ad_oe) else $error("rmw turn");
   AST_WEND: assert property ($rose(write_n) |-> ad_oe ##1 ad_oe) else $error("whold");
   cover property ($fell(write_n) && !drive_enable_n);
   cover property ($fell(write_n));
   cover property (rsp_valid);
endmodule // dpm_host_props
bind dpm_host dpm_host_props chk (.*);
`default_nettype wire

// ===== tb/dpm_ram.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_ram (
   input wire logic select_n,
   input wire logic drive_enable_n,
   input wire logic write_n,
   input wire logic [8:0] ad_out,
   input wire logic ad_oe,
   output wire logic [8:0] ad_in
);
   logic [8:0] mem [0:511];
   logic [8:0] a;
   logic lz, ok, wa;
   realtime ts, te;
   wire rd = !select_n && !drive_enable_n && write_n;
   always #1 begin
      lz = rd && $realtime >= te + 15;
      ok = $realtime >= ts + 120 && $realtime >= te + 55;
   end
   always @(negedge select_n) begin a = ad_out; ts = $realtime; end
   always @(negedge drive_enable_n) te = $realtime;
   always @(negedge write_n or negedge select_n) wa = !write_n && !select_n;
   always @(posedge write_n or posedge select_n) if (wa) begin
      mem[a] = ad_out;
      wa = 0;
   end
   assign ad_in = ad_oe ? ad_out : lz && rd ? (ok ? mem[a] : ~mem[a]) : ~ad_out;
endmodule // dpm_ram
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, reset = 1, req_valid = 0, req_write = 0, req_rmw = 0;
   logic [8:0] req_addr = 0, req_wdata = 0, rsp_rdata, ad_out, ad_in;
   logic req_ready, rsp_valid, select_n, drive_enable_n, write_n, ad_oe;
   int n_errors = 0, check_count = 0;
   dpm_host uut (.*);
   dpm_ram ram (.*);
   initial forever #4 clk = ~clk;
   task chk(input logic [9:0] g, e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %0t got %h exp %h", $time, g, e);
      end
   endtask
   task acc(input logic w, m, input logic [8:0] a, d, e);
      int i;
      for (i = 0; i < 60 && req_ready !== 1; i++) @(posedge clk) #1;
      if (req_ready !== 1) n_errors++;
      {req_valid, req_write, req_rmw, req_addr, req_wdata} = {1'b1, w, m, a, d};
      @(posedge clk) #1;
      req_valid = 0;
      if (!w) begin
         for (i = 0; i < 40 && rsp_valid !== 1; i++) @(posedge clk) #1;
         chk({rsp_valid, rsp_rdata}, {1'b1, e});
      end
   endtask
   task t_wr_rd;
      acc(1, 0, 9'h000, 9'h1a5, 0);
      acc(1, 0, 9'h1ff, 9'h05a, 0);
      acc(0, 0, 9'h000, 0, 9'h1a5);
      acc(0, 0, 9'h1ff, 0, 9'h05a);
      $display("wr_rd done");
   endtask
   task t_rmw;
      acc(0, 1, 9'h1ff, 9'h0c3, 9'h05a);
      acc(0, 0, 9'h1ff, 0, 9'h0c3);
      $display("rmw done");
   endtask
   task conclude;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 reset = 0;
      t_wr_rd;
      t_rmw;
      conclude;
   end
   initial begin
      #20000 n_errors++;
      conclude;
   end
endmodule // tb_top
`default_nettype wire
